// file: bench/pmu_spi_host.sv
// Purpose: Host model sending serial frames to the bank
// Assumes: Mode 0, three system clocks per serial half period
// Notes: Released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module pmu_spi_host
    import pmu_regs_pkg::*;
(
    // System clock and serial data from the bank
    input wire logic clk_sys_i,
    input wire logic sdo_i,
    // Serial pins
    output var spi_in_t spi_o
);
    initial spi_o <= 3'h4;
    // Fewer than 15 pulses gives an aborted frame
    task automatic xfer(input logic [14:0] f, input int n, output logic [7:0] rd,
        output logic ok);
        rd = 8'h00;
        ok = 1'b1;
        spi_o.cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_o.sclk <= 1'b0;
            spi_o.sdi <= f[14-i];
            repeat (3) @(posedge clk_sys_i);
            if (i > 7) rd[14-i] = sdo_i;
            ok &= !(f[14:13] == CMD_WRITE && sdo_i);
            spi_o.sclk <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
            if (i == 6) rd[7] = sdo_i;
        end
        spi_o.sclk <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        spi_o.cs_n <= 1'b1;
        spi_o.sdi <= ~spi_o.sdi;
        repeat (3) @(posedge clk_sys_i);
    endtask : xfer
endmodule : pmu_spi_host
`default_nettype wire

// file: bench/pmu_spi_register_bank_props.sv
// Purpose: Port-level checks of the serial register bank
// Assumes: Host keeps select low past the last rise
// Notes: Counts serial rises itself to know the frame phase
`timescale 1ns/1ps
`default_nettype none
module pmu_spi_register_bank_props
    import pmu_regs_pkg::*;
(
    // Clock, reset and serial pins
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire spi_in_t spi_i,
    input wire logic sdo_o,
    // Status and controls
    input wire status_in_t status_i,
    input wire logic [6:0] core_volt_o,
    input wire logic [5:0] first_volt_o,
    input wire logic [5:0] second_volt_o,
    input wire logic [6:0] core_stby_o,
    input wire logic [4:0] buck_o,
    input wire logic [7:0] comp_o,
    input wire logic linear_reg_sleep_o,
    input wire logic irq_o
);
    logic sclk_q;
    logic [4:0] rises;
    logic [1:0] cmd;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_q <= 1'b0;
            rises <= 5'h00;
            cmd <= 2'b00;
        end else begin
            sclk_q <= spi_i.sclk;
            if (spi_i.cs_n) begin
                rises <= 5'h00;
            end else if (spi_i.sclk && !sclk_q) begin
                rises <= rises + 5'h01;
                if (rises < 5'h02) begin
                    cmd <= {cmd[0], spi_i.sdi};
                end
            end
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    a_sdo_idle_low: assert property (spi_i.cs_n && $past(spi_i.cs_n) |-> !sdo_o)
        else $error("data out active while deselected");
    a_sdo_header_low: assert property (!spi_i.cs_n && rises < 5'h07 |-> !sdo_o)
        else $error("data out active during header");
    a_sdo_write_zero: assert property (rises > 5'h01 && cmd == CMD_WRITE |-> !sdo_o)
        else $error("data out active in write frame");
    a_first_volt_framed: assert property ($changed(first_volt_o) |-> rises == 5'h0f)
        else $error("first code changed outside a full frame");
    a_strap_codes_framed: assert property ($changed({core_volt_o, second_volt_o})
        || $changed(core_stby_o)
        |-> rises == 5'h0f || $past(sys_rst_i, 2) || $past(sys_rst_i, 3))
        else $error("strap code changed without cause");
    a_buck_ctrl_framed: assert property ($changed({buck_o, linear_reg_sleep_o})
        |-> rises == 5'h0f)
        else $error("buck control changed outside a full frame");
    a_comp_ctrl_framed: assert property ($changed(comp_o) |-> rises == 5'h0f)
        else $error("comparator control changed outside a full frame");
    a_irq_has_cause: assert property ($changed(irq_o) |-> rises == 5'h0f
        || $past(sys_rst_i, 2) || $past(status_i, 2) != $past(status_i))
        else $error("interrupt moved without cause");
endmodule : pmu_spi_register_bank_props
bind pmu_spi_register_bank pmu_spi_register_bank_props i_props (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .spi_i(spi_i), .sdo_o(sdo_o),
    .status_i(status_i), .core_volt_o(core_volt_o), .first_volt_o(first_volt_o),
    .second_volt_o(second_volt_o), .core_stby_o(core_stby_o), .irq_o(irq_o),
    .buck_o({first_buck_force_pwm_o, second_buck_force_pwm_o, core_buck_force_pwm_o,
        first_buck_on_o, second_buck_on_o}),
    .comp_o({comp_hyst_o, comp_thres_o, comparator_on_o}),
    .linear_reg_sleep_o(linear_reg_sleep_o));
`default_nettype wire

// file: bench/pmu_spi_register_bank_tb.sv
// Purpose: Self-checking bench of the serial register bank
// Assumes: Host model paces frames; bank clock 125 MHz
// Notes: Straps start core high, second low
`timescale 1ns/1ps
`default_nettype none
module pmu_spi_register_bank_tb
    import pmu_regs_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic core_lvl = 1'b1;
    logic second_lvl = 1'b0;
    logic core_on = 1'b1;
    logic [4:0] st = 5'h00;
    logic ce = 1'b1;
    spi_in_t spi;
    logic sdo_o, first_buck_force_pwm_o, second_buck_force_pwm_o, core_buck_force_pwm_o;
    logic first_buck_on_o, second_buck_on_o, comparator_on_o, comp_hyst_o;
    logic linear_reg_sleep_o, irq_o;
    logic [6:0] core_volt_o, core_stby_o;
    logic [5:0] first_volt_o, second_volt_o, comp_thres_o;
    logic [5:0] alt_second_volt;
    int err_count = 0;
    int tests_run = 0;
    wire logic [7:0] buck_out = {3'h0, first_buck_force_pwm_o, second_buck_force_pwm_o,
        core_buck_force_pwm_o, first_buck_on_o, second_buck_on_o};
    initial forever #4 clk = ~clk;
    pmu_spi_host i_host (.clk_sys_i(clk), .sdo_i(sdo_o), .spi_o(spi));
    pmu_spi_register_bank i_dut (.clk_sys_i(clk), .sys_rst_i(rst), .ce_i(ce),
        .core_level_select_pin_i(core_lvl), .second_level_select_pin_i(second_lvl),
        .spi_i(spi), .sdo_o(sdo_o), .status_i({st, core_on}), .core_volt_o(core_volt_o),
        .first_volt_o(first_volt_o), .second_volt_o(second_volt_o),
        .core_stby_o(core_stby_o), .first_buck_force_pwm_o(first_buck_force_pwm_o),
        .second_buck_force_pwm_o(second_buck_force_pwm_o),
        .core_buck_force_pwm_o(core_buck_force_pwm_o), .first_buck_on_o(first_buck_on_o),
        .second_buck_on_o(second_buck_on_o), .comparator_on_o(comparator_on_o),
        .comp_hyst_o(comp_hyst_o), .comp_thres_o(comp_thres_o),
        .linear_reg_sleep_o(linear_reg_sleep_o), .irq_o(irq_o));
    // Second bank built with the alternate high strap code for the second buck
    pmu_spi_register_bank #(.SECOND_HIGH_USES_ALT(1'b1)) i_dut_alt (.clk_sys_i(clk),
        .sys_rst_i(rst), .ce_i(ce), .core_level_select_pin_i(core_lvl),
        .second_level_select_pin_i(second_lvl), .spi_i(spi), .sdo_o(),
        .status_i({st, core_on}), .core_volt_o(), .first_volt_o(),
        .second_volt_o(alt_second_volt), .core_stby_o(), .first_buck_force_pwm_o(),
        .second_buck_force_pwm_o(), .core_buck_force_pwm_o(), .first_buck_on_o(),
        .second_buck_on_o(), .comparator_on_o(), .comp_hyst_o(), .comp_thres_o(),
        .linear_reg_sleep_o(), .irq_o());
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] rd;
        logic ok;
        i_host.xfer({CMD_WRITE, a, d}, 15, rd, ok);
        check({7'h00, ok}, 8'h01);
    endtask : wr
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] rd;
        logic ok;
        i_host.xfer({CMD_READ, a, 8'h00}, 15, rd, ok);
        check(rd, exp);
    endtask : rd_chk
    task automatic do_reset(input logic core_hi, input logic second_hi);
        @(posedge clk);
        rst <= 1'b1;
        core_lvl <= core_hi;
        second_lvl <= second_hi;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset
    task automatic t_defaults();
        rd_chk(ADDR_CORE_VOLT, 8'h64);
        rd_chk(ADDR_FIRST_VOLT, 8'h26);
        rd_chk(ADDR_SECOND_VOLT, 8'h0e);
        check({2'h0, alt_second_volt}, 8'h0e);
        rd_chk(ADDR_CORE_STBY, 8'h53);
        rd_chk(ADDR_BUCK_CTRL, 8'h83);
        rd_chk(ADDR_COMP_CTRL, 8'h33);
        rd_chk(ADDR_IRQ_EN, 8'h01);
        rd_chk(ADDR_MISC_CTRL, 8'h00);
    endtask : t_defaults
    task automatic t_fields();
        logic [4:0] a [9] = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0b, 5'h0c, 5'h0e, 5'h0d, 5'h1f};
        logic [7:0] m [9] = '{8'h7f, 8'h3f, 8'h3f, 8'h7f, 8'hff, 8'h1f, 8'h03, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++) begin
            wr(a[i], 8'hff);
            rd_chk(a[i], m[i]);
        end
        check({1'b0, core_volt_o}, 8'h7f);
        check({comp_hyst_o, comp_thres_o, comparator_on_o}, 8'hff);
        check({6'h00, linear_reg_sleep_o, irq_o}, 8'h02);
    endtask : t_fields
    task automatic t_irq();
        for (int k = 0; k < 5; k++) begin
            st <= 5'h01 << k;
            repeat (3) @(posedge clk);
            check({7'h00, irq_o}, 8'h01);
            rd_chk(ADDR_IRQ_STAT, 8'h01 << k);
        end
        wr(ADDR_IRQ_EN, 8'h01);
        check({7'h00, irq_o}, 8'h00);
        wr(ADDR_MISC_CTRL, 8'h00);
        check({7'h00, irq_o}, 8'h01);
        st <= 5'h01;
        repeat (3) @(posedge clk);
        check({7'h00, irq_o}, 8'h00);
        st <= 5'h00;
    endtask : t_irq
    task automatic t_buck_abort();
        logic [7:0] rd;
        logic ok;
        core_on <= 1'b0;
        wr(ADDR_BUCK_CTRL, 8'h9c);
        check(buck_out, 8'h1c);
        rd_chk(ADDR_BUCK_CTRL, 8'h1c);
        core_on <= 1'b1;
        i_host.xfer({CMD_WRITE, ADDR_FIRST_VOLT, 8'h05}, 10, rd, ok);
        i_host.xfer({2'b01, ADDR_FIRST_VOLT, 8'h05}, 15, rd, ok);
        check({2'h0, first_volt_o}, 8'h3f);
    endtask : t_buck_abort
    task automatic t_freeze();
        // A frame sent while the enable is low must leave the bank untouched
        ce <= 1'b0;
        wr(ADDR_FIRST_VOLT, 8'h11);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        check({2'h0, first_volt_o}, 8'h3f);
        rd_chk(ADDR_FIRST_VOLT, 8'h3f);
    endtask : t_freeze
    task automatic t_straps();
        do_reset(1'b0, 1'b1);
        rd_chk(ADDR_CORE_VOLT, 8'h3c);
        rd_chk(ADDR_CORE_STBY, 8'h2e);
        rd_chk(ADDR_SECOND_VOLT, 8'h26);
        check({1'b0, core_stby_o}, 8'h2e);
        check({2'h0, second_volt_o}, 8'h26);
        check({2'h0, alt_second_volt}, 8'h12);
    endtask : t_straps
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (50000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    initial begin
        do_reset(1'b1, 1'b0);
        t_defaults();
        t_fields();
        t_irq();
        t_buck_abort();
        t_freeze();
        t_straps();
        wrap_up();
    end
endmodule : pmu_spi_register_bank_tb
`default_nettype wire

// file: src/pmu_regs_pkg.sv
// Purpose: Constants and types for the power-unit serial register bank
// Assumes: 8-bit registers, 5-bit addresses, 2-bit commands per frame
// Notes: Functional notes list bank behaviours, except the first buck code at 0x07 and the interrupt enable at 0x0c
//
// Functional notes
// - 7-bit core buck code at 0x00, strap-dependent reset
// - 6-bit second buck code at 0x08, strap reset
// - 7-bit core standby code at 0x09, strap reset
// - Buck control bit 7 reads core enable status
// - Buck control bits 4..2 force PWM, reset 0
// - Buck control bits 1..0 enable bucks, reset 1
// - Comparator threshold bits 6:1 reset 0x19, enable bit0
// - Comparator bit 7 doubles hysteresis, reset 0
// - Status bits 3..1 show buck outputs good
// - Status bit 4 shows linear regulator good
// - Status bit 0 follows comparator output
// - Misc bit 0 selects interrupt pin polarity
// - Misc bit 1 puts linear regulator asleep
// - Write frame: command, address, data; output zero
// - Read frame: command, address, then register data out
package pmu_regs_pkg;

    // Register addresses
    localparam logic [4:0] ADDR_CORE_VOLT = 5'h00;
    localparam logic [4:0] ADDR_FIRST_VOLT = 5'h07;
    localparam logic [4:0] ADDR_SECOND_VOLT = 5'h08;
    localparam logic [4:0] ADDR_CORE_STBY = 5'h09;
    localparam logic [4:0] ADDR_BUCK_CTRL = 5'h0a;
    localparam logic [4:0] ADDR_COMP_CTRL = 5'h0b;
    localparam logic [4:0] ADDR_IRQ_EN = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_STAT = 5'h0d;
    localparam logic [4:0] ADDR_MISC_CTRL = 5'h0e;

    // Strap-dependent reset values, plus the fixed first buck reset code
    localparam logic [6:0] CORE_VOLT_HIGH = 7'h64;
    localparam logic [6:0] CORE_VOLT_LOW = 7'h3c;
    localparam logic [5:0] FIRST_VOLT_RST = 6'h26;
    localparam logic [5:0] SECOND_VOLT_HIGH = 6'h26;
    localparam logic [5:0] SECOND_VOLT_HIGH_ALT = 6'h12;
    localparam logic [5:0] SECOND_VOLT_LOW = 6'h0e;
    localparam logic [6:0] CORE_STBY_HIGH = 7'h53;
    localparam logic [6:0] CORE_STBY_LOW = 7'h2e;

    // Fixed reset values
    localparam logic [2:0] FORCE_PWM_RST = 3'h0;
    localparam logic [1:0] BUCK_ON_RST = 2'h3;
    localparam logic [5:0] COMP_THRES_RST = 6'h19;
    localparam logic COMP_ON_RST = 1'b1;
    localparam logic COMP_HYST_RST = 1'b0;
    localparam logic [4:0] IRQ_EN_RST = 5'h01;
    localparam logic MISC_BIT_RST = 1'b0;

    // Field positions
    localparam int BUCK_CTRL_CORE_ON_BIT = 7;
    localparam int COMP_HYST_BIT = 7;

    // Frame layout
    localparam logic [1:0] CMD_WRITE = 2'b10;
    localparam logic [1:0] CMD_READ = 2'b11;
    localparam logic [4:0] BITS_HEADER = 5'h07;
    localparam logic [4:0] BITS_FRAME = 5'h0f;

    // Software-visible register contents
    typedef struct packed {
        logic [6:0] core_volt;
        logic [5:0] first_volt;
        logic [5:0] second_volt;
        logic [6:0] core_stby;
        logic [2:0] force_pwm;     // first, second, core
        logic [1:0] buck_on;       // first, second
        logic comp_hyst;
        logic [5:0] comp_thres;
        logic comp_on;
        logic [4:0] irq_en;
        logic linear_reg_sleep;
        logic irq_polarity;
    } reg_file_t;

    // Serial pins from the host
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } spi_in_t;

    // Analog status inputs
    typedef struct packed {
        logic linear_reg_good;
        logic [2:0] buck_good;     // core, second, first
        logic comparator_out;
        logic core_buck_on_status;
    } status_in_t;

    // Whole state of the bank
    typedef struct packed {
        reg_file_t regs;
        logic straps_done;
        logic sclk_prev;
        logic [4:0] bit_cnt;
        logic [14:0] rx_shift;
        logic [7:0] tx_shift;
        logic sdo;
        logic irq;
    } bank_state_t;

endpackage : pmu_regs_pkg

// file: src/pmu_spi_register_bank.sv
// Purpose: Serial-access register bank of a triple buck plus LDO power unit
// Assumes: Serial pins are synchronous to clk_sys_i and much slower than it
// Notes: Mode 0 framing, data in sampled on rising serial clock edges
`timescale 1ns/1ps
`default_nettype none
module pmu_spi_register_bank
    import pmu_regs_pkg::*;
#(
    parameter logic SECOND_HIGH_USES_ALT = 1'b0
) (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Level select straps
    input wire logic core_level_select_pin_i,
    input wire logic second_level_select_pin_i,
    // Serial host interface
    input wire spi_in_t spi_i,
    output logic sdo_o,
    // Analog status
    input wire status_in_t status_i,
    // Regulator controls
    output logic [6:0] core_volt_o,
    output logic [5:0] first_volt_o,
    output logic [5:0] second_volt_o,
    output logic [6:0] core_stby_o,
    output logic first_buck_force_pwm_o,
    output logic second_buck_force_pwm_o,
    output logic core_buck_force_pwm_o,
    output logic first_buck_on_o,
    output logic second_buck_on_o,
    output logic comparator_on_o,
    output logic comp_hyst_o,
    output logic [5:0] comp_thres_o,
    output logic linear_reg_sleep_o,
    // Interrupt pin
    output logic irq_o
);

    bank_state_t state_reg;
    bank_state_t state_next;

    function automatic logic [4:0] live_status(input status_in_t st);
        live_status = {st.linear_reg_good, st.buck_good, st.comparator_out};
    endfunction : live_status

    function automatic logic [7:0] read_reg(input reg_file_t r, input logic [4:0] addr,
                                            input status_in_t st);
        read_reg = 8'h00;
        case (addr)
            ADDR_CORE_VOLT: read_reg = {1'b0, r.core_volt};
            ADDR_FIRST_VOLT: read_reg = {2'b00, r.first_volt};
            ADDR_SECOND_VOLT: read_reg = {2'b00, r.second_volt};
            ADDR_CORE_STBY: read_reg = {1'b0, r.core_stby};
            ADDR_BUCK_CTRL: read_reg = {st.core_buck_on_status, 2'b00, r.force_pwm,
                                        r.buck_on};
            ADDR_COMP_CTRL: read_reg = {r.comp_hyst, r.comp_thres, r.comp_on};
            ADDR_IRQ_EN: read_reg = {3'b000, r.irq_en};
            ADDR_IRQ_STAT: read_reg = {3'b000, live_status(st)};
            ADDR_MISC_CTRL: read_reg = {6'h00, r.linear_reg_sleep, r.irq_polarity};
            default: read_reg = 8'h00;
        endcase
    endfunction : read_reg

    always_comb begin
        logic [4:0] cnt_inc;
        logic [14:0] rx_new;
        logic [7:0] rd_data;
        logic [7:0] wd;
        logic pending;
        cnt_inc = 5'h00;
        rx_new = 15'h0000;
        rd_data = 8'h00;
        wd = 8'h00;
        pending = 1'b0;
        state_next = state_reg;
        state_next.sclk_prev = spi_i.sclk;

        // Straps are captured on the first enabled cycle after reset release
        if (!state_reg.straps_done) begin
            state_next.straps_done = 1'b1;
            state_next.regs.core_volt = core_level_select_pin_i ? CORE_VOLT_HIGH
                                                                : CORE_VOLT_LOW;
            state_next.regs.core_stby = core_level_select_pin_i ? CORE_STBY_HIGH
                                                                : CORE_STBY_LOW;
            if (second_level_select_pin_i) begin
                state_next.regs.second_volt = SECOND_HIGH_USES_ALT ? SECOND_VOLT_HIGH_ALT
                                                                   : SECOND_VOLT_HIGH;
            end else begin
                state_next.regs.second_volt = SECOND_VOLT_LOW;
            end
        end

        if (spi_i.cs_n) begin
            // Frame boundary: partial frames are dropped
            state_next.bit_cnt = 5'h00;
            state_next.sdo = 1'b0;
            state_next.tx_shift = 8'h00;
        end else if (spi_i.sclk && !state_reg.sclk_prev) begin
            if (state_reg.bit_cnt < BITS_FRAME) begin
                cnt_inc = state_reg.bit_cnt + 5'h01;
                rx_new = {state_reg.rx_shift[13:0], spi_i.sdi};
                state_next.bit_cnt = cnt_inc;
                state_next.rx_shift = rx_new;
                pending = (cnt_inc == BITS_HEADER) && (rx_new[6:5] == CMD_READ);
                if (pending) begin
                    rd_data = read_reg(state_reg.regs, rx_new[4:0], status_i);
                    state_next.sdo = rd_data[7];
                    state_next.tx_shift = {rd_data[6:0], 1'b0};
                end
                // Write lands on the last data bit; none lands before the strap capture
                if ((cnt_inc == BITS_FRAME) && (rx_new[14:13] == CMD_WRITE)
                        && state_reg.straps_done) begin
                    wd = rx_new[7:0];
                    case (rx_new[12:8])
                        ADDR_CORE_VOLT: state_next.regs.core_volt = wd[6:0];
                        ADDR_FIRST_VOLT: state_next.regs.first_volt = wd[5:0];
                        ADDR_SECOND_VOLT: state_next.regs.second_volt = wd[5:0];
                        ADDR_CORE_STBY: state_next.regs.core_stby = wd[6:0];
                        ADDR_BUCK_CTRL: begin
                            state_next.regs.force_pwm = wd[4:2];
                            state_next.regs.buck_on = wd[1:0];
                        end
                        ADDR_COMP_CTRL: begin
                            state_next.regs.comp_hyst = wd[COMP_HYST_BIT];
                            state_next.regs.comp_thres = wd[6:1];
                            state_next.regs.comp_on = wd[0];
                        end
                        ADDR_IRQ_EN: state_next.regs.irq_en = wd[4:0];
                        ADDR_MISC_CTRL: begin
                            state_next.regs.linear_reg_sleep = wd[1];
                            state_next.regs.irq_polarity = wd[0];
                        end
                        default: state_next.regs = state_next.regs;
                    endcase
                end
            end
        end else if (!spi_i.sclk && state_reg.sclk_prev) begin
            // Data out changes on falling edges so the host samples it stable
            if ((state_reg.bit_cnt > BITS_HEADER) && (state_reg.bit_cnt < BITS_FRAME)) begin
                state_next.sdo = state_reg.tx_shift[7];
                state_next.tx_shift = {state_reg.tx_shift[6:0], 1'b0};
            end else if (state_reg.bit_cnt == BITS_FRAME) begin
                state_next.sdo = 1'b0;
            end
        end

        // Level interrupt, polarity chosen by software
        state_next.irq = (|(state_reg.regs.irq_en & live_status(status_i)))
                         ~^ state_reg.regs.irq_polarity;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg.regs.core_volt <= CORE_VOLT_LOW;
            state_reg.regs.first_volt <= FIRST_VOLT_RST;
            state_reg.regs.second_volt <= SECOND_VOLT_LOW;
            state_reg.regs.core_stby <= CORE_STBY_LOW;
            state_reg.regs.force_pwm <= FORCE_PWM_RST;
            state_reg.regs.buck_on <= BUCK_ON_RST;
            state_reg.regs.comp_hyst <= COMP_HYST_RST;
            state_reg.regs.comp_thres <= COMP_THRES_RST;
            state_reg.regs.comp_on <= COMP_ON_RST;
            state_reg.regs.irq_en <= IRQ_EN_RST;
            state_reg.regs.linear_reg_sleep <= MISC_BIT_RST;
            state_reg.regs.irq_polarity <= MISC_BIT_RST;
            state_reg.straps_done <= 1'b0;
            state_reg.sclk_prev <= 1'b0;
            state_reg.bit_cnt <= 5'h00;
            state_reg.rx_shift <= 15'h0000;
            state_reg.tx_shift <= 8'h00;
            state_reg.sdo <= 1'b0;
            state_reg.irq <= 1'b1;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    assign sdo_o = state_reg.sdo;
    assign core_volt_o = state_reg.regs.core_volt;
    assign first_volt_o = state_reg.regs.first_volt;
    assign second_volt_o = state_reg.regs.second_volt;
    assign core_stby_o = state_reg.regs.core_stby;
    assign first_buck_force_pwm_o = state_reg.regs.force_pwm[2];
    assign second_buck_force_pwm_o = state_reg.regs.force_pwm[1];
    assign core_buck_force_pwm_o = state_reg.regs.force_pwm[0];
    assign first_buck_on_o = state_reg.regs.buck_on[1];
    assign second_buck_on_o = state_reg.regs.buck_on[0];
    assign comparator_on_o = state_reg.regs.comp_on;
    assign comp_hyst_o = state_reg.regs.comp_hyst;
    assign comp_thres_o = state_reg.regs.comp_thres;
    assign linear_reg_sleep_o = state_reg.regs.linear_reg_sleep;
    assign irq_o = state_reg.irq;

endmodule : pmu_spi_register_bank
`default_nettype wire
